// File: design/hpf_tx_ctrl.sv
// Purpose: transmit hdlc packet controller with 256-byte fifo, apb registers
// Assumes: bit_req_i pulses at most every second clock; inputs synchronous
// Notes: zero-wait apb slave answering through a registered pready
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
module hpf_tx_ctrl #(
   parameter int PORT_NUM = 1
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // apb slave
   input wire logic [hpf_pkg::ADDR_W-1:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [hpf_pkg::DATA_W-1:0] pwdata_i,
   output logic [hpf_pkg::DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // framer bit stream
   input wire logic bit_req_i,
   output logic tx_bit_o,
   // interrupt
   output logic irq_o
);
   import hpf_pkg::*;

   localparam logic [13:0] PORT_OFS = 14'((PORT_NUM - 1) * PORT_STRIDE);

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [13:0] idx);
      addr_hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == idx + PORT_OFS);
   endfunction

   function automatic logic [7:0] bit_rev(input logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         bit_rev[i] = d[7-i];
      end
   endfunction

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
      crc_step = (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY : 16'h0000);
   endfunction

   // registers
   logic [7:0] ctrl_q, thresh_q, tag_q, ev_q, en_q;
   logic [7:0] next_ctrl, next_thresh, next_tag, next_ev, next_en, ev_set;
   logic [DATA_W-1:0] next_prdata;
   logic next_pready, next_pslverr, next_irq;
   // fifo state
   logic [PTR_W-1:0] wr_ptr_q, rd_ptr_q, next_wr_ptr, next_rd_ptr;
   logic [8:0] count_q, next_count, free_now;
   logic [7:0] hold_q, next_hold;
   logic hold_tag_q, next_hold_tag, hold_vld_q, next_hold_vld, rd_pend_q, next_rd_pend;
   logic [5:0] pwr_cnt_q, next_pwr_cnt;
   logic clear_d_q, next_clear_d;
   logic full_q, empty_q, space_q, next_full, next_empty, next_space;
   logic [5:0] grp_q, next_grp;
   logic [WORD_W-1:0] rd_word;
   // tx engine
   hpf_tx_state_t st_q, next_st;
   logic [7:0] sh_q, next_sh, fcs_hi_q, next_fcs_hi;
   logic [2:0] cnt_q, next_cnt, ones_q, next_ones;
   logic [15:0] crc_q, next_crc, crc_n, fcs_word;
   logic last_q, next_last, drop_q, next_drop, next_bit;
   logic consume, under_ev, go;

   // decode and controls
   logic setup, acc, wr, clear, ram_on, empty_now, space_now, wr_byte, rd_en, wr_ok;
   logic hit_ctrl, hit_thr, hit_tag, hit_byte, hit_state, hit_free, hit_ev, hit_en;
   assign setup = psel_i && !penable_i;
   assign acc = psel_i && penable_i && pready_o;
   assign wr = acc && pwrite_i;
   assign hit_ctrl = addr_hit(paddr_i, IDX_CTRL);
   assign hit_thr = addr_hit(paddr_i, IDX_THRESH);
   assign hit_tag = addr_hit(paddr_i, IDX_TAG);
   assign hit_byte = addr_hit(paddr_i, IDX_BYTE);
   assign hit_state = addr_hit(paddr_i, IDX_STATE);
   assign hit_free = addr_hit(paddr_i, IDX_FREE);
   assign hit_ev = addr_hit(paddr_i, IDX_EVENT);
   assign hit_en = addr_hit(paddr_i, IDX_ENABLE);
   assign clear = ctrl_q[CTRL_FIFO_CLEAR];
   // ram usable only after power-up count
   assign ram_on = !clear && (pwr_cnt_q == PWRUP_CNT);
   assign wr_byte = wr && hit_byte && ram_on;
   assign wr_ok = wr_byte && (count_q != FIFO_BYTES);
   assign rd_en = ram_on && (count_q != 9'h000) && !hold_vld_q && !rd_pend_q;
   assign empty_now = (count_q == 9'h000);
   assign free_now = FIFO_BYTES - count_q;
   // threshold is eight times level plus one
   assign space_now = free_now >= ({1'b0, thresh_q[4:0], 3'h0} + THRESH_PLUS);

   hpf_mem u_mem (
      .ref_clk_i(ref_clk_i),
      .ce_i(ce_i),
      .pwr_en_i(ram_on),
      .we_i(wr_ok),
      .waddr_i(wr_ptr_q),
      .wdata_i({tag_q[0], pwdata_i[7:0]}),
      .re_i(rd_en),
      .raddr_i(rd_ptr_q),
      .rdata_o(rd_word)
   );

   // register file and bus answer
   always_comb begin
      next_ctrl = ctrl_q;
      next_thresh = thresh_q;
      next_tag = tag_q;
      next_en = en_q;
      next_pready = setup;
      next_pslverr = 1'b0;
      next_prdata = '0;
      if (setup) begin
         next_pslverr = !(hit_ctrl || hit_thr || hit_tag || hit_byte || hit_state
                          || hit_free || hit_ev || hit_en);
         if (!pwrite_i) begin
            if (hit_ctrl) next_prdata[7:0] = ctrl_q;
            if (hit_thr) next_prdata[7:0] = thresh_q;
            if (hit_tag) next_prdata[7:0] = tag_q;
            if (hit_state) next_prdata[7:0] = {5'h00, full_q, empty_q, space_q};
            if (hit_free) next_prdata[7:0] = {2'h0, grp_q};
            if (hit_ev) next_prdata[7:0] = ev_q;
            if (hit_en) next_prdata[7:0] = en_q;
         end
      end
      if (wr && hit_ctrl) next_ctrl = pwdata_i[7:0] & CTRL_MASK;
      if (wr && hit_thr) next_thresh = pwdata_i[7:0] & THRESH_MASK;
      if (wr && hit_tag) next_tag = pwdata_i[7:0] & TAG_MASK;
      if (wr && hit_en) next_en = pwdata_i[7:0] & EV_MASK;
      // write one to clear, a new event wins
      next_ev = ev_q & ~((wr && hit_ev) ? pwdata_i[7:0] : 8'h00);
      next_ev = (next_ev | ev_set) & EV_MASK;
      next_irq = |(ev_q & en_q);
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         ctrl_q <= CTRL_RESET;
         thresh_q <= THRESH_RESET;
         tag_q <= 8'h00;
         ev_q <= 8'h00;
         en_q <= 8'h00;
         prdata_o <= '0;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         irq_o <= 1'b0;
      end else if (ce_i) begin
         ctrl_q <= next_ctrl;
         thresh_q <= next_thresh;
         tag_q <= next_tag;
         ev_q <= next_ev;
         en_q <= next_en;
         prdata_o <= next_prdata;
         pready_o <= next_pready;
         pslverr_o <= next_pslverr;
         irq_o <= next_irq;
      end
   end

   // fifo pointers, hold stage, status
   always_comb begin
      next_wr_ptr = wr_ptr_q;
      next_rd_ptr = rd_ptr_q;
      next_count = count_q;
      next_hold = hold_q;
      next_hold_tag = hold_tag_q;
      next_hold_vld = hold_vld_q && !consume;
      next_rd_pend = rd_en;
      next_pwr_cnt = pwr_cnt_q;
      next_clear_d = clear;
      ev_set = 8'h00;
      if (clear) begin
         // empty the fifo and power the ram down
         next_wr_ptr = '0;
         next_rd_ptr = '0;
         next_count = 9'h000;
         next_hold_vld = 1'b0;
         next_rd_pend = 1'b0;
         next_pwr_cnt = 6'h00;
      end else begin
         if (pwr_cnt_q != PWRUP_CNT) next_pwr_cnt = pwr_cnt_q + 6'h01;
         if (wr_ok) next_wr_ptr = wr_ptr_q + 8'h01;
         if (rd_en) next_rd_ptr = rd_ptr_q + 8'h01;
         // hold stage still counts as stored, so a byte leaves only when the engine takes it
         next_count = count_q + {8'h00, wr_ok} - {8'h00, consume};
         if (rd_pend_q) begin
            next_hold = rd_word[7:0];
            next_hold_tag = rd_word[8];
            next_hold_vld = 1'b1;
         end
      end
      // overflow on a write to a full fifo
      ev_set[EV_OVER] = wr_byte && (count_q == FIFO_BYTES);
      ev_set[EV_UNDER] = under_ev;
      // marked byte read out of the fifo
      ev_set[EV_DONE] = consume && hold_tag_q && !clear;
      ev_set[EV_EMPTY] = (empty_now && !empty_q) || (clear_d_q && !clear);
      ev_set[EV_SPACE] = (space_now && !space_q) || (clear_d_q && !clear);
      next_full = (count_q == FIFO_BYTES);
      next_empty = empty_now;
      next_space = space_now;
      next_grp = free_now[8:3];
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= 9'h000;
         hold_q <= 8'h00;
         hold_tag_q <= 1'b0;
         hold_vld_q <= 1'b0;
         rd_pend_q <= 1'b0;
         pwr_cnt_q <= 6'h00;
         clear_d_q <= 1'b0;
         full_q <= 1'b0;
         empty_q <= 1'b0;
         space_q <= 1'b0;
         grp_q <= 6'h00;
      end else if (ce_i) begin
         wr_ptr_q <= next_wr_ptr;
         rd_ptr_q <= next_rd_ptr;
         count_q <= next_count;
         hold_q <= next_hold;
         hold_tag_q <= next_hold_tag;
         hold_vld_q <= next_hold_vld;
         rd_pend_q <= next_rd_pend;
         pwr_cnt_q <= next_pwr_cnt;
         clear_d_q <= next_clear_d;
         full_q <= next_full;
         empty_q <= next_empty;
         space_q <= next_space;
         grp_q <= next_grp;
      end
   end

   // transmit engine, one bit per bit_req_i
   always_comb begin
      next_st = st_q;
      next_sh = sh_q;
      next_cnt = cnt_q;
      next_ones = ones_q;
      next_crc = crc_q;
      next_fcs_hi = fcs_hi_q;
      next_last = last_q;
      next_drop = drop_q;
      next_bit = tx_bit_o;
      consume = 1'b0;
      under_ev = 1'b0;
      crc_n = crc_q;
      // error insertion leaves the crc uninverted
      fcs_word = ctrl_q[CTRL_FCS_ERR] ? crc_n : crc_n ^ CRC_XOROUT;
      // no new packet while start disabled
      go = hold_vld_q && !drop_q && !ctrl_q[CTRL_START_DIS];
      if (clear) begin
         next_st = TX_IDLE;
         next_sh = FLAG_OCTET;
         next_cnt = 3'h0;
         next_ones = 3'h0;
         next_drop = 1'b0;
      end else begin
         // bytes of an underflowed packet are thrown away
         if (drop_q && hold_vld_q) begin
            consume = 1'b1;
            if (hold_tag_q) next_drop = 1'b0;
         end
         if (bit_req_i) begin
            if (ones_q == STUFF_LIMIT) begin
               next_bit = ctrl_q[CTRL_INVERT];
               next_ones = 3'h0;
            end else begin
               next_bit = sh_q[0] ^ ctrl_q[CTRL_INVERT];
               next_ones = ((st_q == TX_DATA || st_q == TX_FCS_LO || st_q == TX_FCS_HI)
                            && sh_q[0]) ? ones_q + 3'h1 : 3'h0;
               if (st_q == TX_DATA) crc_n = crc_step(crc_q, sh_q[0]);
               fcs_word = ctrl_q[CTRL_FCS_ERR] ? crc_n : crc_n ^ CRC_XOROUT;
               next_crc = crc_n;
               next_sh = {1'b0, sh_q[7:1]};
               next_cnt = cnt_q + 3'h1;
               if (cnt_q == LAST_BIT) begin
                  case (st_q)
                     TX_OPEN: begin
                        next_sh = ctrl_q[CTRL_MSB_FIRST] ? bit_rev(hold_q) : hold_q;
                        next_last = hold_tag_q;
                        consume = 1'b1;
                        next_crc = CRC_INIT;
                        next_st = TX_DATA;
                     end
                     TX_DATA: begin
                        if (last_q) begin
                           if (ctrl_q[CTRL_FCS_DISABLE]) begin
                              next_sh = FLAG_OCTET;
                              next_st = TX_CLOSE;
                           end else begin
                              next_sh = fcs_word[7:0];
                              next_fcs_hi = fcs_word[15:8];
                              next_st = TX_FCS_LO;
                           end
                        end else if (hold_vld_q && !drop_q) begin
                           next_sh = ctrl_q[CTRL_MSB_FIRST] ? bit_rev(hold_q) : hold_q;
                           next_last = hold_tag_q;
                           consume = 1'b1;
                        end else begin
                           under_ev = 1'b1;
                           next_drop = 1'b1;
                           next_sh = FLAG_OCTET;
                           next_st = TX_CLOSE;
                        end
                     end
                     TX_FCS_LO: begin
                        next_sh = fcs_hi_q;
                        next_st = TX_FCS_HI;
                     end
                     TX_FCS_HI: begin
                        next_sh = FLAG_OCTET;
                        next_st = TX_CLOSE;
                     end
                     default: begin
                        if (go) begin
                           next_sh = FLAG_OCTET;
                           next_st = TX_OPEN;
                        end else begin
                           next_sh = ctrl_q[CTRL_IDLE_FILL] ? ONES_OCTET : FLAG_OCTET;
                           next_st = TX_IDLE;
                        end
                     end
                  endcase
               end
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         st_q <= TX_IDLE;
         sh_q <= FLAG_OCTET;
         cnt_q <= 3'h0;
         ones_q <= 3'h0;
         crc_q <= CRC_INIT;
         fcs_hi_q <= 8'h00;
         last_q <= 1'b0;
         drop_q <= 1'b0;
         tx_bit_o <= 1'b1;
      end else if (ce_i) begin
         st_q <= next_st;
         sh_q <= next_sh;
         cnt_q <= next_cnt;
         ones_q <= next_ones;
         crc_q <= next_crc;
         fcs_hi_q <= next_fcs_hi;
         last_q <= next_last;
         drop_q <= next_drop;
         tx_bit_o <= next_bit;
      end
   end

   byte_read_zero_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (ce_i && setup && !pwrite_i && hit_byte) |=> (prdata_o == '0))
      else $error("byte register read not zero");
   full_flag_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      ce_i |=> (full_q == ($past(count_q) == FIFO_BYTES)) && (empty_q == ($past(count_q) == 0)))
      else $error("full or empty status wrong");
   space_cmp_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      ce_i |=> (space_q == ($past(free_now) >= {1'b0, $past(thresh_q[4:0]), 3'h0} + 9'h001)))
      else $error("space status wrong");
   free_grp_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      ce_i |=> ({grp_q, 3'h0} <= $past(free_now)) && ($past(free_now) < {grp_q, 3'h0} + 9'h008))
      else $error("free group count wrong");
   overflow_set_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (ce_i && wr_byte && full_q && count_q == FIFO_BYTES) |=> ev_q[EV_OVER] && count_q <= $past(count_q))
      else $error("overflow not latched");
   clear_empty_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (ce_i && clear) |=> (count_q == 0) && !hold_vld_q && st_q == TX_IDLE)
      else $error("fifo clear did not empty");
   powerup_wait_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (ce_i && $fell(clear)) |-> !ram_on [*8])
      else $error("ram used before power-up");
   release_set_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (ce_i && clear_d_q && !clear) |=> ev_q[EV_EMPTY] && ev_q[EV_SPACE])
      else $error("clear release did not set latches");
   sticky_flag_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (ce_i && !(wr && hit_ev)) |=> ((ev_q & $past(ev_q)) == $past(ev_q)))
      else $error("latched flag dropped");
   irq_gate_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      ce_i |=> (irq_o == |($past(ev_q) & $past(en_q))))
      else $error("interrupt not gated by enable");
   stuff_zero_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (ce_i && !clear && bit_req_i && ones_q == STUFF_LIMIT) |=> (tx_bit_o == $past(ctrl_q[CTRL_INVERT])))
      else $error("no zero inserted after five ones");
   invert_bit_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (ce_i && !clear && bit_req_i && ones_q != STUFF_LIMIT)
      |=> (tx_bit_o == ($past(sh_q[0]) ^ $past(ctrl_q[CTRL_INVERT]))))
      else $error("output bit inversion wrong");
   start_hold_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (ce_i && ctrl_q[CTRL_START_DIS] && st_q == TX_IDLE) |=> (st_q != TX_OPEN))
      else $error("packet started while disabled");
   done_cov_c: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) ev_set[EV_DONE]);
   under_cov_c: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) under_ev);
   fcs_cov_c: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) st_q == TX_FCS_HI);
   over_cov_c: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) ev_set[EV_OVER]);
endmodule

// File: design/hpf_pkg.sv
// Purpose: constants and types shared by the hdlc transmit fifo block
// Assumes: apb with 32-bit data, one word per register
// Notes: printed offsets are word indices, byte address is four times the index
package hpf_pkg;
   // timing
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned PWRUP_TIME_NS = 1000;
   localparam int unsigned PWRUP_CYCLES = (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [5:0] PWRUP_CNT = 6'(PWRUP_CYCLES);
   // register indices of port 1, stride between ports
   localparam logic [13:0] IDX_CTRL = 14'h1500;
   localparam logic [13:0] IDX_THRESH = 14'h1501;
   localparam logic [13:0] IDX_TAG = 14'h1502;
   localparam logic [13:0] IDX_BYTE = 14'h1503;
   localparam logic [13:0] IDX_STATE = 14'h1504;
   localparam logic [13:0] IDX_FREE = 14'h1505;
   localparam logic [13:0] IDX_EVENT = 14'h1506;
   localparam logic [13:0] IDX_ENABLE = 14'h1508;
   localparam logic [13:0] PORT_STRIDE = 14'h0020;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 32;
   // control bits
   localparam int unsigned CTRL_FIFO_CLEAR = 0;
   localparam int unsigned CTRL_FCS_DISABLE = 1;
   localparam int unsigned CTRL_INVERT = 2;
   localparam int unsigned CTRL_MSB_FIRST = 3;
   localparam int unsigned CTRL_IDLE_FILL = 4;
   localparam int unsigned CTRL_FCS_ERR = 5;
   localparam int unsigned CTRL_START_DIS = 6;
   localparam logic [7:0] CTRL_MASK = 8'h7f;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] THRESH_MASK = 8'h1f;
   localparam logic [7:0] THRESH_RESET = 8'h08;
   localparam logic [7:0] TAG_MASK = 8'h01;
   // event latch and enable bit positions
   localparam int unsigned EV_SPACE = 0;
   localparam int unsigned EV_EMPTY = 1;
   localparam int unsigned EV_DONE = 3;
   localparam int unsigned EV_UNDER = 4;
   localparam int unsigned EV_OVER = 5;
   localparam logic [7:0] EV_MASK = 8'h3b;
   // fifo geometry
   localparam int unsigned PTR_W = 8;
   localparam int unsigned WORD_W = 9;
   localparam logic [8:0] FIFO_BYTES = 9'h100;
   localparam logic [8:0] THRESH_PLUS = 9'h001;
   // line coding
   localparam logic [7:0] FLAG_OCTET = 8'h7e;
   localparam logic [7:0] ONES_OCTET = 8'hff;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'h8408;
   localparam logic [15:0] CRC_XOROUT = 16'hffff;
   localparam logic [2:0] STUFF_LIMIT = 3'h5;
   localparam logic [2:0] LAST_BIT = 3'h7;
   typedef enum logic [2:0] {
      TX_IDLE,
      TX_OPEN,
      TX_DATA,
      TX_FCS_LO,
      TX_FCS_HI,
      TX_CLOSE
   } hpf_tx_state_t;
endpackage

// File: design/hpf_mem.sv
// Purpose: 256-word fifo store, byte plus packet-end mark
// Assumes: one write and one read port, read data registered
// Notes: nothing is stored or read while power is off
`timescale 1ns/10ps
module hpf_mem (
   // clock
   input wire logic ref_clk_i,
   input wire logic ce_i,
   input wire logic pwr_en_i,
   // write port
   input wire logic we_i,
   input wire logic [hpf_pkg::PTR_W-1:0] waddr_i,
   input wire logic [hpf_pkg::WORD_W-1:0] wdata_i,
   // read port
   input wire logic re_i,
   input wire logic [hpf_pkg::PTR_W-1:0] raddr_i,
   output logic [hpf_pkg::WORD_W-1:0] rdata_o
);
   import hpf_pkg::*;
   logic [WORD_W-1:0] mem [2**PTR_W];

   always_ff @(posedge ref_clk_i) begin
      if (ce_i && pwr_en_i && we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      if (ce_i && pwr_en_i && re_i) begin
         rdata_o <= mem[raddr_i];
      end
   end
endmodule

// File: sim/hpf_framer_model.sv
// Purpose: framer side model, pulls bits and keeps the last sixteen
// Assumes: a bit request every second clock, every fourth when slow
// Notes: a bit is taken the cycle after its request
`timescale 1ns/10ps
module hpf_framer_model (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // bit stream
   input wire logic slow_i,
   input wire logic tx_bit_i,
   output logic bit_req_o,
   output logic [15:0] seen_o
);
   logic [1:0] cnt;
   logic req_d;
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         cnt <= 2'h0;
         req_d <= 1'b0;
         seen_o <= 16'h0;
      end else begin
         cnt <= cnt + 2'h1;
         req_d <= bit_req_o;
         if (req_d) seen_o <= {tx_bit_i, seen_o[15:1]};
      end
   end
   // slow mode widens the gap to stress the transmit path
   assign bit_req_o = ~sys_rst_i & (slow_i ? (cnt == 2'h0) : ~cnt[0]);
endmodule

// File: sim/hpf_tx_ctrl_bench.sv
// Purpose: register and line level test of the transmit fifo block
// Assumes: port 1 registers, zero-wait apb slave
// Notes: line checks count ones over the last sixteen bits
`timescale 1ns/10ps
module hpf_tx_ctrl_bench;
   import hpf_pkg::*;
   logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, slow = 1'b0, err, pready, pslverr, bit_req, tx_bit, irq;
   logic [15:0] paddr = 16'h0, seen;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [7:0] rd;
   logic [7:0] modes [4] = '{8'h00, 8'h10, 8'h14, 8'h04};
   logic [7:0] ones [4] = '{8'h0c, 8'h10, 8'h00, 8'h04};
   int errors = 0, checked = 0, cyc = 0;
   hpf_tx_ctrl i_hpf_tx_ctrl (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
      .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .bit_req_i(bit_req), .tx_bit_o(tx_bit), .irq_o(irq));
   hpf_framer_model i_hpf_framer_model (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .slow_i(slow), .tx_bit_i(tx_bit), .bit_req_o(bit_req), .seen_o(seen));
   initial begin
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         end_of_test();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [3:0] idx, input logic [7:0] d);
      @(posedge ref_clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= 16'h5400 + {10'h0, idx, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge ref_clk_i);
      penable <= 1'b1;
      @(posedge ref_clk_i);
      while (pready !== 1'b1) @(posedge ref_clk_i);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [3:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(rd, exp);
   endtask
   initial begin
      repeat (4) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      repeat (50) @(posedge ref_clk_i);
      rdchk(4'h0, 8'h00);
      rdchk(4'h1, 8'h08);
      rdchk(4'h4, 8'h03);
      rdchk(4'h5, 8'h20);
      apb(1'b0, 4'h7, 8'h00);
      chk({7'h0, err}, 8'h01);
      $display("registers done");
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, 4'h0, modes[m]);
         repeat (80) @(posedge ref_clk_i);
         chk(8'($countones(seen)), ones[m]);
      end
      $display("idle fill done");
      apb(1'b1, 4'h1, 8'h00);
      apb(1'b1, 4'h0, 8'h40);
      apb(1'b1, 4'h6, 8'h3b);
      apb(1'b1, 4'h8, 8'h20);
      for (int i = 0; i < 255; i++) apb(1'b1, 4'h3, 8'(i));
      rdchk(4'h4, 8'h01);
      apb(1'b1, 4'h3, 8'hff);
      rdchk(4'h4, 8'h04);
      rdchk(4'h5, 8'h00);
      apb(1'b1, 4'h3, 8'h00);
      rdchk(4'h6, 8'h20);
      rdchk(4'h3, 8'h00);
      chk({7'h0, irq}, 8'h01);
      $display("fill done");
      apb(1'b1, 4'h0, 8'h41);
      apb(1'b1, 4'h3, 8'h11);
      rdchk(4'h4, 8'h03);
      apb(1'b1, 4'h0, 8'h40);
      repeat (50) @(posedge ref_clk_i);
      rdchk(4'h6, 8'h23);
      apb(1'b1, 4'h6, 8'h3b);
      rdchk(4'h6, 8'h00);
      chk({7'h0, irq}, 8'h00);
      $display("clear done");
      apb(1'b1, 4'h2, 8'h01);
      apb(1'b1, 4'h3, 8'h7e);
      repeat (200) @(posedge ref_clk_i);
      rdchk(4'h6, 8'h00);
      slow <= 1'b1;
      apb(1'b1, 4'h0, 8'h00);
      repeat (500) @(posedge ref_clk_i);
      rdchk(4'h6, 8'h0a);
      chk(8'($countones(seen)), 8'h0c);
      $display("packet done");
      end_of_test();
   end
endmodule
